// File: core/rca_pkg.sv
package rca_pkg;

   // register word offsets on the bus (byte addresses, low byte decoded)
   localparam logic [7:0] OFS_WEEKDAY = 8'h00;
   localparam logic [7:0] OFS_DATE = 8'h04;
   localparam logic [7:0] OFS_MONTH = 8'h08;
   localparam logic [7:0] OFS_YEAR = 8'h0C;
   localparam logic [7:0] OFS_SEC_ALARM = 8'h10;
   localparam logic [7:0] OFS_MIN_ALARM = 8'h14;
   localparam logic [7:0] OFS_HOUR_ALARM = 8'h18;
   localparam logic [7:0] OFS_WKDAY_ALARM = 8'h1C;
   localparam logic [7:0] OFS_CTRL_ONE = 8'h20;
   localparam logic [7:0] OFS_CTRL_TWO = 8'h24;

   // field positions
   localparam int ENB_BIT = 7;
   localparam int START_BIT = 0;
   localparam int AIE_BIT = 3;
   localparam int FLAG_BIT = 0;

   // values after reset
   localparam logic [7:0] CTRL_TWO_RESET = 8'h09;
   localparam logic CTRL_ONE_RESET = 1'b0;
   localparam logic ENB_RESET = 1'b0;

   // calendar limits in bcd
   localparam logic [2:0] WEEKDAY_FIRST = 3'h0;
   localparam logic [2:0] WEEKDAY_LAST = 3'h6;
   localparam logic [7:0] DATE_FIRST = 8'h01;
   localparam logic [7:0] MONTH_FIRST = 8'h01;
   localparam logic [7:0] MONTH_LAST = 8'h12;
   localparam logic [7:0] MONTH_FEB = 8'h02;
   localparam logic [7:0] YEAR_FIRST = 8'h00;
   localparam logic [7:0] YEAR_LAST = 8'h99;
   localparam logic [7:0] DAYS_31 = 8'h31;
   localparam logic [7:0] DAYS_30 = 8'h30;
   localparam logic [7:0] DAYS_29 = 8'h29;
   localparam logic [7:0] DAYS_28 = 8'h28;

   typedef enum logic [1:0] {BUS_IDLE, BUS_WRITE, BUS_READ, BUS_RDONE}
      rca_bus_st_t;

   function automatic logic [7:0] rca_bcd_inc(input logic [7:0] v);
      if (v[3:0] == 4'h9) begin
         rca_bcd_inc = {v[7:4] + 4'h1, 4'h0};
      end else begin
         rca_bcd_inc = {v[7:4], v[3:0] + 4'h1};
      end
   endfunction

endpackage

// File: core/rca_month_len.sv
`timescale 1ns/1ns
module rca_month_len
   import rca_pkg::*;
(
   input wire logic [7:0] month,
   input wire logic [7:0] year,
   output logic leap,
   output logic [7:0] last_day
);
   // year mod 4 from bcd: ten is 10 mod 4 = 2, so odd tens add two
   always_comb begin
      leap = ((year[1:0] + {year[4], 1'b0}) == 2'h0);
   end

   always_comb begin
      unique case (month)
         8'h04, 8'h06, 8'h09, 8'h11: last_day = DAYS_30;
         MONTH_FEB: last_day = leap ? DAYS_29 : DAYS_28;
         default: last_day = DAYS_31;
      endcase
   end
endmodule // rca_month_len

// File: core/rca_ahb_port.sv
`timescale 1ns/1ns
module rca_ahb_port
   import rca_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   output logic [7:0] reg_addr,
   output logic reg_wr,
   output logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata
);
   rca_bus_st_t state_q;
   logic [7:0] addr_q;
   logic take;

   // a read costs one wait state so the data leave a register and never
   // race a write landing in the same cycle
   always_comb begin
      take = hsel && htrans[1] && hready && (state_q != BUS_READ);
      reg_addr = addr_q;
      reg_wr = (state_q == BUS_WRITE);
      reg_wdata = hwdata[7:0];
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_q <= BUS_IDLE;
         addr_q <= 8'h00;
      end else if (take) begin
         state_q <= hwrite ? BUS_WRITE : BUS_READ;
         addr_q <= haddr[7:0];
      end else if (state_q == BUS_READ) begin
         state_q <= BUS_RDONE;
      end else begin
         state_q <= BUS_IDLE;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         hreadyout <= 1'b1;
         hrdata <= 32'h0000_0000;
         hresp <= 1'b0;
      end else begin
         hresp <= 1'b0;
         hreadyout <= !(take && !hwrite);
         if (state_q == BUS_READ) begin
            hrdata <= {24'h00_0000, reg_rdata};
         end
      end
   end
endmodule // rca_ahb_port

// File: core/rca_calendar.sv
// Our own choices: the AHB-Lite slave port and the address map.
`timescale 1ns/1ns
module rca_calendar
   import rca_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic day_carry,
   input wire logic [7:0] seconds_count,
   input wire logic [7:0] minutes_count,
   input wire logic [7:0] hours_count,
   output logic counting,
   output logic alarm_irq
);
   logic [7:0] reg_addr;
   logic reg_wr;
   logic [7:0] reg_wdata;
   logic [7:0] reg_rdata;

   logic [2:0] weekday_q;
   logic [5:0] date_q;
   logic [4:0] month_q;
   logic [7:0] year_q;
   logic [6:0] sec_al_q;
   logic [6:0] min_al_q;
   logic [5:0] hour_al_q;
   logic [2:0] wk_al_q;
   logic [3:0] enb_q;
   logic [7:0] ctrl_two_q;
   logic aie_q;
   logic flag_q;
   logic match_q;

   logic [7:0] date_full;
   logic [7:0] month_full;
   logic [7:0] date_next;
   logic [7:0] month_next;
   logic [7:0] last_day;
   logic leap;
   logic tick;
   logic month_carry;
   logic year_carry;
   logic [3:0] field_eq;
   logic match;
   logic match_rise;
   logic wr_week;
   logic wr_date;
   logic wr_month;
   logic wr_year;
   logic wr_ctrl_one;

   // hsize is accepted but only whole words are meaningful here
   rca_ahb_port u_port (
      .clk(clk),
      .rst(rst),
      .hsel(hsel),
      .haddr(haddr),
      .htrans(htrans),
      .hwrite(hwrite),
      .hwdata(hwdata),
      .hready(hready),
      .hreadyout(hreadyout),
      .hresp(hresp),
      .hrdata(hrdata),
      .reg_addr(reg_addr),
      .reg_wr(reg_wr),
      .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata)
   );

   rca_month_len u_len (
      .month(month_full),
      .year(year_q),
      .leap(leap),
      .last_day(last_day)
   );

   always_comb begin
      date_full = {2'b00, date_q};
      month_full = {3'b000, month_q};
      date_next = rca_bcd_inc(date_full);
      month_next = rca_bcd_inc(month_full);
      wr_week = reg_wr && (reg_addr == OFS_WEEKDAY);
      wr_date = reg_wr && (reg_addr == OFS_DATE);
      wr_month = reg_wr && (reg_addr == OFS_MONTH);
      wr_year = reg_wr && (reg_addr == OFS_YEAR);
      wr_ctrl_one = reg_wr && (reg_addr == OFS_CTRL_ONE);
   end

   // carry chain; gated by start so a halted clock ignores the hour carry
   always_comb begin
      tick = day_carry && ctrl_two_q[START_BIT];
      month_carry = tick && (date_full == last_day);
      year_carry = month_carry && (month_full == MONTH_LAST);
   end

   // calendar counters carry no reset: they must survive every reset
   always_ff @(posedge clk) begin
      if (wr_week) begin
         weekday_q <= reg_wdata[2:0];
      end else if (tick) begin
         if (weekday_q == WEEKDAY_LAST) begin
            weekday_q <= WEEKDAY_FIRST;
         end else begin
            weekday_q <= weekday_q + 3'h1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (wr_date) begin
         date_q <= reg_wdata[5:0];
      end else if (month_carry) begin
         date_q <= DATE_FIRST[5:0];
      end else if (tick) begin
         date_q <= date_next[5:0];
      end
   end

   always_ff @(posedge clk) begin
      if (wr_month) begin
         month_q <= reg_wdata[4:0];
      end else if (year_carry) begin
         month_q <= MONTH_FIRST[4:0];
      end else if (month_carry) begin
         month_q <= month_next[4:0];
      end
   end

   always_ff @(posedge clk) begin
      if (wr_year) begin
         year_q <= reg_wdata;
      end else if (year_carry) begin
         if (year_q == YEAR_LAST) begin
            year_q <= YEAR_FIRST;
         end else begin
            year_q <= rca_bcd_inc(year_q);
         end
      end
   end

   // alarm fields keep their value through reset; only enables are cleared
   always_ff @(posedge clk) begin
      if (reg_wr && (reg_addr == OFS_SEC_ALARM)) begin
         sec_al_q <= reg_wdata[6:0];
      end
      if (reg_wr && (reg_addr == OFS_MIN_ALARM)) begin
         min_al_q <= reg_wdata[6:0];
      end
      if (reg_wr && (reg_addr == OFS_HOUR_ALARM)) begin
         hour_al_q <= reg_wdata[5:0];
      end
      if (reg_wr && (reg_addr == OFS_WKDAY_ALARM)) begin
         wk_al_q <= reg_wdata[2:0];
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         enb_q <= {4{ENB_RESET}};
      end else if (reg_wr) begin
         if (reg_addr == OFS_SEC_ALARM) begin
            enb_q[0] <= reg_wdata[ENB_BIT];
         end
         if (reg_addr == OFS_MIN_ALARM) begin
            enb_q[1] <= reg_wdata[ENB_BIT];
         end
         if (reg_addr == OFS_HOUR_ALARM) begin
            enb_q[2] <= reg_wdata[ENB_BIT];
         end
         if (reg_addr == OFS_WKDAY_ALARM) begin
            enb_q[3] <= reg_wdata[ENB_BIT];
         end
      end
   end

   // with no enable set nothing is compared, so no alarm can fire
   always_comb begin
      field_eq[0] = (sec_al_q == seconds_count[6:0]);
      field_eq[1] = (min_al_q == minutes_count[6:0]);
      field_eq[2] = (hour_al_q == hours_count[5:0]);
      field_eq[3] = (wk_al_q == weekday_q);
      match = (|enb_q) && (&(~enb_q | field_eq));
      match_rise = match && !match_q;
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         match_q <= 1'b0;
      end else begin
         match_q <= match;
      end
   end

   // the flag is set on the first cycle of a match only; a level set would
   // refill it at once while the match persists for a whole second
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         flag_q <= CTRL_ONE_RESET;
      end else if (match_rise) begin
         flag_q <= 1'b1;
      end else if (wr_ctrl_one && !reg_wdata[FLAG_BIT]) begin
         flag_q <= 1'b0;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         aie_q <= CTRL_ONE_RESET;
      end else if (wr_ctrl_one) begin
         aie_q <= reg_wdata[AIE_BIT];
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ctrl_two_q <= CTRL_TWO_RESET;
      end else if (reg_wr && (reg_addr == OFS_CTRL_TWO)) begin
         ctrl_two_q <= reg_wdata;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         alarm_irq <= 1'b0;
         counting <= CTRL_TWO_RESET[START_BIT];
      end else begin
         alarm_irq <= flag_q && aie_q;
         counting <= ctrl_two_q[START_BIT];
      end
   end

   // unused and reserved bits read as zero, except ctrl_two, which reads back every bit written
   always_comb begin
      unique case (reg_addr)
         OFS_WEEKDAY: reg_rdata = {5'h00, weekday_q};
         OFS_DATE: reg_rdata = date_full;
         OFS_MONTH: reg_rdata = month_full;
         OFS_YEAR: reg_rdata = year_q;
         OFS_SEC_ALARM: reg_rdata = {enb_q[0], sec_al_q};
         OFS_MIN_ALARM: reg_rdata = {enb_q[1], min_al_q};
         OFS_HOUR_ALARM: reg_rdata = {enb_q[2], 1'b0, hour_al_q};
         OFS_WKDAY_ALARM: reg_rdata = {enb_q[3], 4'h0, wk_al_q};
         OFS_CTRL_ONE: reg_rdata = {4'h0, aie_q, 2'b00, flag_q};
         OFS_CTRL_TWO: reg_rdata = ctrl_two_q;
         default: reg_rdata = 8'h00;
      endcase
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   property p_weekday_step;
      tick && !wr_week && (weekday_q < WEEKDAY_LAST)
         |=> weekday_q == $past(weekday_q) + 3'h1;
   endproperty
   a_weekday_step: assert property (p_weekday_step)
      else $error("weekday did not step on day carry");

   property p_weekday_wrap;
      tick && !wr_week && (weekday_q == WEEKDAY_LAST)
         |=> weekday_q == WEEKDAY_FIRST;
   endproperty
   a_weekday_wrap: assert property (p_weekday_wrap)
      else $error("weekday did not wrap to sunday");

   property p_date_roll;
      month_carry && !wr_date && !wr_month
         |=> date_full == DATE_FIRST && month_full != $past(month_full);
   endproperty
   a_date_roll: assert property (p_date_roll)
      else $error("date did not roll over with month carry");

   property p_month_wrap;
      year_carry && !wr_month && !wr_year
         |=> month_full == MONTH_FIRST && year_q != $past(year_q);
   endproperty
   a_month_wrap: assert property (p_month_wrap)
      else $error("month did not wrap with year carry");

   property p_year_wrap;
      year_carry && !wr_year && (year_q == YEAR_LAST)
         |=> year_q == YEAR_FIRST;
   endproperty
   a_year_wrap: assert property (p_year_wrap)
      else $error("year did not wrap from 99");

   // case equality: counters never loaded since power-up must also hold
   property p_halted;
      !ctrl_two_q[START_BIT] && !reg_wr
         |=> weekday_q === $past(weekday_q) && date_q === $past(date_q)
            && month_q === $past(month_q) && year_q === $past(year_q);
   endproperty
   a_halted: assert property (p_halted)
      else $error("calendar moved while halted");

   property p_leap_feb;
      (month_full == MONTH_FEB) && (year_q == 8'h00 || year_q == 8'h12
         || year_q == 8'h96) |-> last_day == DAYS_29;
   endproperty
   a_leap_feb: assert property (p_leap_feb)
      else $error("leap february not 29 days");

   property p_flag_set;
      match && !match_q |=> flag_q ##1 alarm_irq == aie_q;
   endproperty
   a_flag_set: assert property (p_flag_set)
      else $error("alarm flag or irq wrong after match");

   property p_no_enable;
      enb_q == 4'h0 && !flag_q |=> !flag_q;
   endproperty
   a_no_enable: assert property (p_no_enable)
      else $error("alarm matched with no compare enabled");

   property p_enb_reset;
      $fell(rst) |-> enb_q == 4'h0;
   endproperty
   a_enb_reset: assert property (disable iff (1'b0) p_enb_reset)
      else $error("compare enables not cleared by reset");

endmodule // rca_calendar

// File: dv/rtc_calendar_and_alarm_compare_bench.sv
`timescale 1ns/1ns
module rtc_calendar_and_alarm_compare_bench;
   import rca_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   logic hreadyout;
   logic hresp;
   logic [31:0] hrdata;
   logic day_carry = 1'b0;
   logic [7:0] seconds_count = 8'h0;
   logic [7:0] minutes_count = 8'h0;
   logic [7:0] hours_count = 8'h0;
   logic counting;
   logic alarm_irq;
   int n_fail = 0;
   int n_checks = 0;
   int seed = 32'hF1616323;
   logic rd_dph = 1'b0;
   logic [31:0] exp_q[$];
   string name_q[$];
   logic [7:0] s_v;
   logic [7:0] m_v;
   logic [7:0] h_v;
   // upper bits of each value except the minute alarm 45 are set so that masking on write shows
   logic [7:0] mw[9] = '{8'hFD, 8'hE5, 8'hF1, 8'h97, 8'hD9, 8'h45, 8'hD3,
      8'hFB, 8'hFF};
   logic [7:0] mr[9] = '{8'h05, 8'h25, 8'h11, 8'h97, 8'hD9, 8'h45, 8'h93,
      8'h83, 8'h00};
   logic [7:0] ar[9] = '{8'h05, 8'h25, 8'h11, 8'h97, 8'h59, 8'h45, 8'h13,
      8'h03, 8'h00};
   // {weekday, date, month, year} before and after the carries
   logic [31:0] cal_in[12] = '{32'h06311299, 32'h02280201, 32'h02280200,
      32'h04290296, 32'h01300410, 32'h00300112, 32'h03090719, 32'h05301109,
      32'h00300919, 32'h06300403, 32'h03280212, 32'h06311219};
   logic [31:0] cal_ex[12] = '{32'h00010100, 32'h03010301, 32'h03290200,
      32'h05010396, 32'h02010510, 32'h01310112, 32'h04100719, 32'h06011209,
      32'h01011019, 32'h01020503, 32'h04290212, 32'h00010120};
   int ncar[12] = '{1, 1, 1, 1, 1, 1, 1, 1, 1, 2, 1, 1};

   rca_calendar dut (
      .clk(clk),
      .rst(rst),
      .hsel(hsel),
      .haddr(haddr),
      .htrans(htrans),
      .hwrite(hwrite),
      .hsize(hsize),
      .hwdata(hwdata),
      .hready(hreadyout),
      .hreadyout(hreadyout),
      .hresp(hresp),
      .hrdata(hrdata),
      .day_carry(day_carry),
      .seconds_count(seconds_count),
      .minutes_count(minutes_count),
      .hours_count(hours_count),
      .counting(counting),
      .alarm_irq(alarm_irq)
   );

   always #50 clk = ~clk;

   task check(string nm, logic [31:0] seen, logic [31:0] ex);
      n_checks++;
      if (seen !== ex) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", nm, ex, seen);
      end
   endtask

   task finish_test;
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // one single transfer; every signal held until hready is seen high
   task bus(logic [7:0] a, logic w, logic [31:0] d);
      @(posedge clk);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      @(posedge clk);
      while (hreadyout !== 1'b1) @(posedge clk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge clk);
      while (hreadyout !== 1'b1) @(posedge clk);
   endtask

   task wr(logic [7:0] a, logic [7:0] d);
      bus(a, 1'b1, {24'h0, d});
   endtask

   task rd(logic [7:0] a, logic [7:0] ex, string nm);
      exp_q.push_back({24'h0, ex});
      name_q.push_back(nm);
      bus(a, 1'b0, 32'h0);
   endtask

   // read data is judged at the edge that ends the data phase
   always @(posedge clk) begin
      if (rd_dph && hreadyout === 1'b1) begin
         check(name_q.pop_front(), hrdata, exp_q.pop_front());
         check("hresp", {31'h0, hresp}, 32'h0);
         rd_dph <= 1'b0;
      end
      if (hsel && htrans[1] && !hwrite && hreadyout === 1'b1) begin
         rd_dph <= 1'b1;
      end
   end

   function automatic logic [7:0] rbcd(int n);
      int v;
      v = {$random(seed)} % n;
      return {4'(v / 10), 4'(v % 10)};
   endfunction

   task pulse(int n);
      repeat (n) begin
         @(posedge clk);
         day_carry <= 1'b1;
      end
      @(posedge clk);
      day_carry <= 1'b0;
   endtask

   task do_reset(int n);
      rst <= 1'b1;
      repeat (n) @(posedge clk);
      rst <= 1'b0;
   endtask

   task set_cal(logic [31:0] v);
      wr(OFS_WEEKDAY, v[31:24]);
      wr(OFS_DATE, v[23:16]);
      wr(OFS_MONTH, v[15:8]);
      wr(OFS_YEAR, v[7:0]);
   endtask

   task chk_cal(logic [31:0] v);
      rd(OFS_WEEKDAY, v[31:24], "weekday");
      rd(OFS_DATE, v[23:16], "date");
      rd(OFS_MONTH, v[15:8], "month");
      rd(OFS_YEAR, v[7:0], "year");
   endtask

   initial begin
      #2000000;
      n_fail++;
      finish_test;
   end

   initial begin
      do_reset(12);
      #1;
      check("counting", {31'h0, counting}, 32'h1);
      check("alarm_irq", {31'h0, alarm_irq}, 32'h0);
      rd(OFS_CTRL_TWO, 8'h09, "ctrl_two");
      rd(OFS_CTRL_ONE, 8'h00, "ctrl_one");
      wr(OFS_CTRL_TWO, 8'h08);
      repeat (2) @(posedge clk);
      #1;
      check("counting", {31'h0, counting}, 32'h0);
      // index 8 is an unmapped word: write ignored, reads zero
      for (int i = 0; i < 9; i++) begin
         wr(i == 8 ? 8'h40 : 8'(i * 4), mw[i]);
      end
      for (int i = 0; i < 9; i++) begin
         rd(i == 8 ? 8'h40 : 8'(i * 4), mr[i], "masked");
      end
      do_reset(2);
      for (int i = 0; i < 9; i++) begin
         rd(i == 8 ? 8'h40 : 8'(i * 4), ar[i], "kept");
      end
      for (int i = 0; i < 12; i++) begin
         wr(OFS_CTRL_TWO, 8'h08);
         set_cal(cal_in[i]);
         wr(OFS_CTRL_TWO, 8'h09);
         pulse(ncar[i]);
         wr(OFS_CTRL_TWO, 8'h08);
         pulse(1);
         chk_cal(cal_ex[i]);
      end
      // weekday counter is 0 now; the hour field is wrong on pass 1
      for (int it = 1; it >= 0; it--) begin
         s_v = rbcd(60);
         m_v = rbcd(60);
         h_v = rbcd(24);
         seconds_count <= s_v ^ 8'h01;
         minutes_count <= m_v;
         hours_count <= h_v;
         wr(OFS_SEC_ALARM, s_v | 8'h80);
         wr(OFS_MIN_ALARM, m_v ^ 8'h01);
         wr(OFS_HOUR_ALARM, (it == 1 ? h_v ^ 8'h01 : h_v) | 8'h80);
         wr(OFS_WKDAY_ALARM, 8'h80);
         wr(OFS_CTRL_ONE, 8'h08);
         @(posedge clk);
         seconds_count <= s_v;
         @(posedge clk);
         #1;
         check("alarm_irq", {31'h0, alarm_irq}, 32'h0);
         @(posedge clk);
         #1;
         check("alarm_irq", {31'h0, alarm_irq}, it == 0);
         rd(OFS_CTRL_ONE, it == 0 ? 8'h09 : 8'h08, "flag");
      end
      wr(OFS_CTRL_ONE, 8'h09);
      rd(OFS_CTRL_ONE, 8'h09, "flag_kept");
      wr(OFS_CTRL_ONE, 8'h01);
      repeat (2) @(posedge clk);
      #1;
      check("alarm_irq", {31'h0, alarm_irq}, 32'h0);
      rd(OFS_CTRL_ONE, 8'h01, "flag_masked");
      wr(OFS_CTRL_ONE, 8'h00);
      rd(OFS_CTRL_ONE, 8'h00, "flag_cleared");
      repeat (4) @(posedge clk);
      finish_test;
   end
endmodule // rtc_calendar_and_alarm_compare_bench
